// >>> hdl/flash_host_ctl.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "flash_ctl_defs.svh"
// Contract
// - High-voltage ID needs bit-nine qualifier, bit six low
// - Sector address high bits; 01h protected
// - ID readable by command sequence, no qualifier
// - Host protects all sectors before unprotect; the controller leaves this to software
// - Protect uses reset qualifier and bus cycles
// - Program and erase need unlock sequence
// - Write needs CE, WE low, OE high
// - Limit flag or ID mode needs reset
module flash_host_ctl
   import flash_ctl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [31:0] sw_rdata,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic      [19:0] flash_addr,
   input  wire logic [15:0] flash_dq_in,
   output logic      [15:0] flash_dq_out,
   output logic             flash_dq_oe_n,
   output logic             flash_reset_n,
   output logic             id_volt_on_a9,
   output logic             unprot_volt_on_reset
);
   typedef struct packed {
      seq_state_t  st;
      logic [3:0]  op;
      logic [2:0]  step;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        id_mode;
      logic        abort;
      logic        start;
      logic        write;
      logic [19:0] c_addr;
      logic [15:0] c_wdata;
      logic [31:0] sw_rdata;
      logic [2:0]  pins;
   } ctl_t;
   ctl_t s_r, s_nxt;
   logic cyc_last;
   logic [19:0] cyc_a;
   logic [15:0] cyc_d;

   bus_cycle_if cyc ();

   flash_pin_engine u_eng (
      .mclk    (mclk),
      .reset   (reset),
      .cyc     (cyc.eng),
      .dq_in   (flash_dq_in),
      .ce_n    (flash_ce_n),
      .oe_n    (flash_oe_n),
      .we_n    (flash_we_n),
      .addr_o  (flash_addr),
      .dq_out  (flash_dq_out),
      .dq_oe_n (flash_dq_oe_n)
   );

   // Bus cycle for a given step of the current operation.
   function automatic logic [35:0] step_cycle(input logic [3:0] op, input logic [2:0] st,
                                              input logic [19:0] a, input logic [15:0] d);
      logic [19:0] ca;
      logic [7:0]  cd;
      ca = `UNLOCK_ADR1;
      cd = `UNLOCK_D1;
      case (st)
         3'd0: begin
            ca = `UNLOCK_ADR1;
            cd = `UNLOCK_D1;
         end
         3'd1: begin
            ca = `UNLOCK_ADR2;
            cd = `UNLOCK_D2;
         end
         3'd2: begin
            ca = `UNLOCK_ADR1;
            cd = (op == `OP_PROG) ? `CMD_PROG :
                 (op == `OP_ERASE) ? `CMD_ERASE_SET : `CMD_ID;
         end
         3'd3: begin
            ca = `UNLOCK_ADR1;
            cd = `UNLOCK_D1;
         end
         default: begin
            ca = `UNLOCK_ADR2;
            cd = `UNLOCK_D2;
         end
      endcase
      return {ca, 8'h00, cd};
   endfunction : step_cycle

   // Last unlock or command step of each sequence; program and erase then add
   // one more cycle that carries the target address.
   function automatic logic [2:0] last_step(input logic [3:0] op);
      case (op)
         `OP_ID_ENTER: return 3'd2;
         `OP_PROG:     return 3'd2;
         `OP_ERASE:    return 3'd4;
         default:      return 3'd0;
      endcase
   endfunction : last_step

   // ======================================================================
   // Sequencer: software orders become bus cycles on the flash pins.
   always_comb begin
      s_nxt          = s_r;
      s_nxt.start    = 1'b0;
      cyc_last       = (s_r.step == last_step(s_r.op));
      {cyc_a, cyc_d} = step_cycle(s_r.op, s_r.step, s_r.addr, s_r.wdata);
      if (sw_rd) begin
         case (sw_addr)
            `REG_ADDR:   s_nxt.sw_rdata = {12'h000, s_r.addr};
            `REG_WDATA:  s_nxt.sw_rdata = {16'h0000, s_r.wdata};
            `REG_STATUS: s_nxt.sw_rdata = {29'h0, s_r.abort, s_r.id_mode,
                                           (s_r.st != S_IDLE)};
            `REG_RDATA:  s_nxt.sw_rdata = {16'h0000, s_r.rdata};
            `REG_PINS:   s_nxt.sw_rdata = {29'h0, s_r.pins};
            default:     s_nxt.sw_rdata = 32'h0000_0000;
         endcase
      end
      if (sw_wr) begin
         case (sw_addr)
            `REG_ADDR:  s_nxt.addr  = sw_wdata[19:0];
            `REG_WDATA: s_nxt.wdata = sw_wdata[15:0];
            // Bit0 holds the device in reset, bit1 address-bit-nine qualifier,
            // bit2 reset qualifier for protect or temporary unprotect.
            // Protecting every sector before an unprotect is left to software.
            `REG_PINS:  s_nxt.pins  = sw_wdata[2:0];
            `REG_CMD: begin
               // Orders are dropped while busy rather than queued.
               if (s_r.st == S_IDLE) begin
                  s_nxt.op    = sw_wdata[3:0];
                  s_nxt.step  = 3'd0;
                  s_nxt.abort = 1'b0;
                  s_nxt.st    = S_SETUP;
               end
            end
            default: ;
         endcase
      end
      case (s_r.st)
         S_IDLE: ;
         S_SETUP: begin
            s_nxt.start = 1'b1;
            s_nxt.st    = S_STROBE;
            case (s_r.op)
               `OP_READ, `OP_HW_ID: begin
                  // High-voltage ID read keeps address bit six low.
                  s_nxt.write  = 1'b0;
                  s_nxt.c_addr = (s_r.op == `OP_HW_ID) ?
                                 {s_r.addr[19:7], 1'b0, s_r.addr[5:0]} : s_r.addr;
               end
               `OP_ID_READ: begin
                  // Low byte picks the code; sector sits in high bits.
                  s_nxt.write  = 1'b0;
                  s_nxt.c_addr = s_r.addr;
               end
               `OP_WRITE: begin
                  s_nxt.write   = 1'b1;
                  s_nxt.c_addr  = s_r.addr;
                  s_nxt.c_wdata = s_r.wdata;
               end
               `OP_RESET_CMD: begin
                  // Leaves ID mode or limit-exceeded status.
                  s_nxt.write   = 1'b1;
                  s_nxt.c_addr  = `UNLOCK_ADR1;
                  s_nxt.c_wdata = {8'h00, `CMD_RESET};
               end
               `OP_ID_ENTER, `OP_PROG, `OP_ERASE: begin
                  // Unlock cycles before any alteration.
                  s_nxt.write   = 1'b1;
                  s_nxt.c_addr  = cyc_a;
                  s_nxt.c_wdata = cyc_d;
                  if (s_r.step > last_step(s_r.op)) begin
                     // Final cycle carries target address and data.
                     s_nxt.c_addr  = s_r.addr;
                     s_nxt.c_wdata = (s_r.op == `OP_ERASE) ?
                                     {8'h00, `CMD_SECT_ERASE} : s_r.wdata;
                  end
               end
               default: begin
                  s_nxt.start = 1'b0;
                  s_nxt.abort = 1'b1;
                  s_nxt.st    = S_IDLE;
               end
            endcase
         end
         S_STROBE: begin
            if (cyc.done) begin
               s_nxt.rdata = cyc.rdata;
               s_nxt.st    = S_NEXT;
            end
         end
         default: begin
            s_nxt.st = S_IDLE;
            if ((s_r.op == `OP_ID_ENTER) && cyc_last) begin
               s_nxt.id_mode = 1'b1;
            end else if (s_r.op == `OP_RESET_CMD) begin
               s_nxt.id_mode = 1'b0;
            end
            if (((s_r.op == `OP_PROG) || (s_r.op == `OP_ERASE)) &&
                (s_r.step <= last_step(s_r.op))) begin
               s_nxt.step = s_r.step + 3'd1;
               s_nxt.st   = S_SETUP;
            end else if ((s_r.op == `OP_ID_ENTER) && !cyc_last) begin
               s_nxt.step = s_r.step + 3'd1;
               s_nxt.st   = S_SETUP;
            end
         end
      endcase
      // Reset pin low ends the device's operation and its ID mode.
      if (s_r.pins[`PIN_HOLD]) begin
         s_nxt.id_mode = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '{st: S_IDLE, op: 4'h0, step: 3'd0, addr: 20'h00000,
                  wdata: 16'h0000, rdata: 16'h0000, id_mode: 1'b0, abort: 1'b0,
                  start: 1'b0, write: 1'b0, c_addr: 20'h00000, c_wdata: 16'h0000,
                  sw_rdata: 32'h0000_0000, pins: 3'h0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cyc.start            = s_r.start;
   assign cyc.write            = s_r.write;
   assign cyc.addr             = s_r.c_addr;
   assign cyc.wdata            = s_r.c_wdata;
   assign sw_rdata             = s_r.sw_rdata;
   assign flash_reset_n        = ~s_r.pins[`PIN_HOLD];
   assign id_volt_on_a9        = s_r.pins[`PIN_NINE_QUAL];
   assign unprot_volt_on_reset = s_r.pins[`PIN_RST_QUAL];
endmodule : flash_host_ctl

// >>> hdl/flash_ctl_defs.svh
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH
// ==========================================================================
// Register map of the controller, word offsets on the software port.
`define REG_CMD        4'h0
`define REG_ADDR       4'h1
`define REG_WDATA      4'h2
`define REG_STATUS     4'h3
`define REG_RDATA      4'h4
`define REG_PINS       4'h5
// Command codes written to the command register.
`define OP_READ        4'h1
`define OP_WRITE       4'h2
`define OP_ID_ENTER    4'h3
`define OP_ID_READ     4'h4
`define OP_RESET_CMD   4'h5
`define OP_PROG        4'h6
`define OP_ERASE       4'h7
`define OP_HW_ID       4'h8
// Bus command values and unlock addresses.
`define UNLOCK_ADR1    20'h00555
`define UNLOCK_ADR2    20'h002AA
`define UNLOCK_D1      8'hAA
`define UNLOCK_D2      8'h55
`define CMD_ID         8'h90
`define CMD_RESET      8'hF0
`define CMD_PROG       8'hA0
`define CMD_ERASE_SET  8'h80
`define CMD_SECT_ERASE 8'h30
// Identification read offsets in the low address byte.
`define ID_MFR         8'h00
`define ID_DEV         8'h01
`define ID_PROT        8'h02
`define ID_CONT        8'h03
// Strobe phase length in clocks, less one (40 ns each, well above any glitch filter).
`define PHASE_CYC      3'h2
// Status bit positions.
`define ST_BUSY        0
`define ST_ID_MODE     1
`define ST_ABORT       2
// Pin-control bit positions in the pins register.
`define PIN_HOLD       0
`define PIN_NINE_QUAL  1
`define PIN_RST_QUAL   2
`endif

// >>> hdl/flash_ctl_pkg.sv
package flash_ctl_pkg;
   // ======================================================================
   // Sequencer states.
   typedef enum logic [2:0] {
      S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_NEXT
   } seq_state_t;
endpackage : flash_ctl_pkg

// >>> hdl/bus_cycle_if.sv
`timescale 1ns/10ps
// One bus cycle request from the sequencer to the pin engine.
interface bus_cycle_if;
   logic        start;
   logic        write;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;
   modport seq (output start, output write, output addr, output wdata,
                input done, input rdata);
   modport eng (input start, input write, input addr, input wdata,
                output done, output rdata);
endinterface : bus_cycle_if

// >>> hdl/flash_pin_engine.sv
`timescale 1ns/10ps
`include "flash_ctl_defs.svh"
module flash_pin_engine
   import flash_ctl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   bus_cycle_if.eng         cyc,
   input  wire logic [15:0] dq_in,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [19:0]      addr_o,
   output logic [15:0]      dq_out,
   output logic             dq_oe_n
);
   typedef struct packed {
      logic [1:0]  ph;
      logic [2:0]  cnt;
      logic        wr;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic [19:0] addr;
      logic [15:0] dq;
      logic        dq_oe_n;
      logic        done;
      logic [15:0] rd;
   } eng_t;
   eng_t s_r, s_nxt;

   // ======================================================================
   // Phase 0 sets address with strobes high; phase 1 lowers CE with WE or OE
   // together; phase 2 raises them together so address and data are both
   // stable at the latching edges. Strobes never overlap OE with WE.
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      case (s_r.ph)
         2'd0: begin
            if (cyc.start) begin
               s_nxt.ph      = 2'd1;
               s_nxt.cnt     = `PHASE_CYC;
               s_nxt.wr      = cyc.write;
               s_nxt.addr    = cyc.addr;
               s_nxt.dq      = cyc.wdata;
               s_nxt.dq_oe_n = ~cyc.write;
            end
         end
         2'd1: begin
            // Address is stable before the later falling edge.
            s_nxt.ce_n = 1'b0;
            s_nxt.we_n = ~s_r.wr;
            s_nxt.oe_n = s_r.wr;
            s_nxt.cnt  = s_r.cnt - 3'h1;
            if (s_r.cnt == 3'h0) begin
               s_nxt.ph = 2'd2;                    // Pulse spans clocks.
            end
         end
         default: begin
            // Data held until after the first rising edge.
            s_nxt.rd      = s_r.oe_n ? s_r.rd : dq_in;
            s_nxt.ce_n    = 1'b1;
            s_nxt.we_n    = 1'b1;
            s_nxt.oe_n    = 1'b1;
            s_nxt.dq_oe_n = 1'b1;
            s_nxt.ph      = 2'd0;
            s_nxt.done    = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '{ph: 2'd0, cnt: 3'h0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                  we_n: 1'b1, addr: 20'h00000, dq: 16'h0000, dq_oe_n: 1'b1,
                  done: 1'b0, rd: 16'h0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ce_n      = s_r.ce_n;
   assign oe_n      = s_r.oe_n;
   assign we_n      = s_r.we_n;
   assign addr_o    = s_r.addr;
   assign dq_out    = s_r.dq;
   assign dq_oe_n   = s_r.dq_oe_n;
   assign cyc.done  = s_r.done;
   assign cyc.rdata = s_r.rd;
endmodule : flash_pin_engine

// >>> test/flash_host_ctl_asserts.sv
`timescale 1ns/10ps
// ==========================================================================
// Pin-level checks on the flash strobes driven by the controller.
module flash_host_ctl_asserts (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        flash_ce_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_we_n,
   input wire logic [19:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic        flash_dq_oe_n,
   input wire logic        flash_reset_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Each strobe is low for three clocks, far above the glitch filter.
   sequence we_pulse;
      !flash_we_n [*3] ##1 flash_we_n;
   endsequence
   sequence oe_pulse;
      !flash_oe_n [*3] ##1 flash_oe_n;
   endsequence
   AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> we_pulse)
      else $error("write strobe width wrong");
   AST_OE_WIDTH: assert property ($fell(flash_oe_n) |-> oe_pulse)
      else $error("read strobe width wrong");
   AST_WRITE_QUAL: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
      else $error("write strobe without chip enable or with output enable");
   AST_ADDR_HELD: assert property (!flash_we_n || !flash_oe_n |-> $stable(flash_addr))
      else $error("address moved under a strobe");
   AST_DATA_HELD: assert property (!flash_we_n |-> $stable(flash_dq_out) && !flash_dq_oe_n)
      else $error("write data moved or undriven under the strobe");
   AST_NO_CLASH: assert property (!flash_oe_n |-> flash_dq_oe_n)
      else $error("host drives data while the part drives it");
   AST_CE_RELEASE: assert property ($rose(flash_we_n) |-> flash_ce_n)
      else $error("chip enable outlives the write strobe");
   AST_IDLE_START: assert property ($fell(reset) |->
      flash_we_n && flash_ce_n && flash_oe_n && flash_dq_oe_n && flash_reset_n)
      else $error("pins not idle after reset");
endmodule : flash_host_ctl_asserts

// >>> test/flash_dev_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Behavioural flash part; only sixteen words and sixteen sectors are kept.
module flash_dev_model #(
   parameter logic [15:0] PROT_PRESET = 16'h0000,
   parameter logic [7:0]  MFR_CODE    = 8'h5C, // Arbitrary value.
   parameter logic [7:0]  DEV_CODE    = 8'h6D, // Arbitrary value.
   parameter logic [7:0]  DEV_UPPER   = 8'h2E, // Arbitrary value.
   parameter logic [7:0]  CONT_CODE   = 8'h4E  // Arbitrary value.
) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq_w,
   input  wire logic        reset_n,
   input  wire logic        id_volt,
   input  wire logic        tmp_unprot,
   output logic      [15:0] dq
);
   logic [15:0] mem [0:15];
   logic [15:0] prot = PROT_PRESET; // Never altered by temporary unprotect.
   logic [19:0] lat_addr = 20'h00000;
   logic [15:0] held = 16'h0000;
   logic [2:0]  step = 3'h0; // Power-up lands in read array.
   logic        id_mode = 1'b0;
   logic        prog_armed = 1'b0;
   logic        wr_open = 1'b0; // Strobes low at power-up never open a write.
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = {i[3:0], 12'h0A5};
      end
   end
   // Address taken when the later strobe falls, only with output enable high.
   always @(negedge we_n or negedge ce_n) begin
      if (!we_n && !ce_n && oe_n && reset_n) begin
         lat_addr = addr;
         wr_open = 1'b1;
      end
   end
   // Data taken on the first rising strobe; wrong values drop the sequence.
   always @(posedge we_n or posedge ce_n or negedge reset_n) begin
      if (!reset_n) begin
         step = 3'h0;
         id_mode = 1'b0;
         prog_armed = 1'b0;
         wr_open = 1'b0;
      end else if (wr_open) begin
         wr_open = 1'b0;
         if (prog_armed) begin
            if (!prot[lat_addr[18:15]] || tmp_unprot) begin
               mem[lat_addr[3:0]] = dq_w; // Back to read array at once.
            end
            prog_armed = 1'b0;
         end else if (dq_w[7:0] == 8'hF0) begin
            step = 3'h0;
            id_mode = 1'b0;
         end else if ((step == 3'h0 || step == 3'h3) && lat_addr[11:0] == 12'h555 &&
                      dq_w[7:0] == 8'hAA) begin
            step = step + 3'h1;
         end else if ((step == 3'h1 || step == 3'h4) && lat_addr[11:0] == 12'h2AA &&
                      dq_w[7:0] == 8'h55) begin
            step = step + 3'h1;
         end else if (step == 3'h2 && lat_addr[11:0] == 12'h555 && dq_w[7:0] == 8'h90) begin
            id_mode = 1'b1;
            step = 3'h0;
         end else if (step == 3'h2 && lat_addr[11:0] == 12'h555 && dq_w[7:0] == 8'hA0) begin
            prog_armed = 1'b1;
            step = 3'h0;
         end else if (step == 3'h2 && lat_addr[11:0] == 12'h555 && dq_w[7:0] == 8'h80) begin
            step = 3'h3; // Erase set-up; a second unlock pair must follow.
         end else if (step == 3'h5 && dq_w[7:0] == 8'h30) begin
            // Erase clears only the addressed word, which is enough to see it happen.
            if (!prot[lat_addr[18:15]] || tmp_unprot) begin
               mem[lat_addr[3:0]] = 16'hFFFF;
            end
            step = 3'h0;
         end else begin
            step = 3'h0;
         end
      end
   end
   // Identification codes come from the id_volt qualifier input or the command-entered ID mode.
   function automatic logic [15:0] rd_val(input logic [19:0] a);
      logic [7:0] sel;
      sel = 8'hFF;
      if (id_volt && !a[6]) begin
         sel = {6'h00, a[1:0]};
      end else if (id_mode) begin
         sel = a[7:0];
      end
      case (sel)
         8'h00:   rd_val = {8'h00, MFR_CODE};
         8'h01:   rd_val = {DEV_UPPER, DEV_CODE};
         8'h02:   rd_val = {15'h0000, prot[a[18:15]]};
         8'h03:   rd_val = {8'h00, CONT_CODE};
         default: rd_val = mem[a[3:0]]; // Nothing is erase-suspended, so array data.
      endcase
   endfunction : rd_val
   // A floating bus shows the inverse of the last word, never a stale match.
   always @* begin
      if (!ce_n && !oe_n && reset_n) begin
         dq = rd_val(addr);
         held = dq;
      end else begin
         dq = ~held;
      end
   end
endmodule : flash_dev_model

// >>> test/flash_mode_protect_control_test.sv
`timescale 1ns/10ps
`include "flash_ctl_defs.svh"
// ==========================================================================
// Bench for the flash controller against the behavioural part.
module flash_mode_protect_control_test;
   import flash_ctl_pkg::*;
   localparam logic [7:0] MFR  = 8'h5C; // Arbitrary value.
   localparam logic [7:0] DEVC = 8'h6D; // Arbitrary value.
   localparam logic [7:0] CONT = 8'h4E; // Arbitrary value.
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0000_0000;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   logic [31:0] sw_rdata, got;
   logic        ce_n, oe_n, we_n, dq_oe_n, rst_n, volt_nine, volt_rst;
   logic [19:0] faddr;
   logic [15:0] dq_in, dq_out, v;
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;
`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t ns got %h expected %h", $time, (g), (e)); end end
   always #20 mclk = ~mclk;
   flash_host_ctl dut (.mclk(mclk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe_n(dq_oe_n), .flash_reset_n(rst_n), .id_volt_on_a9(volt_nine),
      .unprot_volt_on_reset(volt_rst));
   // Sector one starts protected so that refusal and temporary unprotect can be seen.
   flash_dev_model #(.PROT_PRESET(16'h0002), .MFR_CODE(MFR), .DEV_CODE(DEVC),
      .CONT_CODE(CONT)) part (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
      .dq_w(dq_out), .reset_n(rst_n), .id_volt(volt_nine), .tmp_unprot(volt_rst), .dq(dq_in));
   // ======================================================================
   // Software port cycles and operation helpers.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask : rd
   // Busy is polled under a bound so a stuck sequencer cannot hang the run.
   task automatic run_op(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d);
      int n;
      wr(`REG_ADDR, {12'h000, a});
      wr(`REG_WDATA, {16'h0000, d});
      wr(`REG_CMD, {28'h0000000, op});
      repeat (2) @(posedge mclk);
      n = 0;
      rd(`REG_STATUS, got);
      while (got[`ST_BUSY] !== 1'b0 && n < 40) begin
         rd(`REG_STATUS, got);
         n++;
      end
      if (n == 40) fail_count++;
   endtask : run_op
   task automatic fetch(input logic [3:0] op, input logic [19:0] a, output logic [15:0] r);
      run_op(op, a, 16'h0000);
      rd(`REG_RDATA, got);
      r = got[15:0];
   endtask : fetch
   function automatic logic [7:0] id_exp(input int k, input logic p);
      id_exp = (k == 0) ? MFR : (k == 1) ? DEVC : (k == 2) ? {7'h00, p} : CONT;
   endfunction : id_exp
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   // ======================================================================
   // Scenarios.
   task automatic t_reset;
      rd(`REG_STATUS, got);
      `CHECK(got, 32'h0000_0000)
      `CHECK({ce_n, we_n, oe_n, dq_oe_n, rst_n}, 5'h1F)
      rd(4'hE, got);
      `CHECK(got, 32'h0000_0000)
      fetch(`OP_READ, 20'h00003, v);
      `CHECK(v, 16'h30A5)
      $display("reset and array read done");
   endtask : t_reset
   task automatic t_program;
      run_op(`OP_WRITE, 20'h00555, 16'h00A0);
      run_op(`OP_WRITE, 20'h00006, 16'h0000);
      fetch(`OP_READ, 20'h00006, v);
      `CHECK(v, 16'h60A5)
      run_op(`OP_PROG, 20'h00002, 16'h1234);
      fetch(`OP_READ, 20'h00002, v);
      `CHECK(v, 16'h1234)
      run_op(`OP_PROG, 20'h08004, 16'h5555);
      fetch(`OP_READ, 20'h08004, v);
      `CHECK(v, 16'h40A5)
      wr(`REG_PINS, 32'h0000_0004);
      #1 `CHECK(volt_rst, 1'b1)
      run_op(`OP_PROG, 20'h08004, 16'h5555);
      wr(`REG_PINS, 32'h0000_0000);
      fetch(`OP_READ, 20'h08004, v);
      `CHECK(v, 16'h5555)
      run_op(`OP_PROG, 20'h08004, 16'h0000);
      fetch(`OP_READ, 20'h08004, v);
      `CHECK(v, 16'h5555)
      run_op(`OP_ERASE, 20'h00007, 16'h0000);
      fetch(`OP_READ, 20'h00007, v);
      `CHECK(v, 16'hFFFF)
      run_op(`OP_ERASE, 20'h08009, 16'h0000);
      fetch(`OP_READ, 20'h08009, v);
      `CHECK(v, 16'h90A5)
      $display("program and protection done");
   endtask : t_program
   task automatic t_ident;
      run_op(`OP_ID_ENTER, 20'h00000, 16'h0000);
      rd(`REG_STATUS, got);
      `CHECK(got, 32'h0000_0002)
      for (int k = 0; k < 4; k++) begin
         fetch(`OP_ID_READ, 20'h08000 | 20'(k), v);
         `CHECK(v[7:0], id_exp(k, 1'b1))
      end
      fetch(`OP_READ, 20'h00000, v);
      `CHECK(v[7:0], MFR)
      run_op(`OP_RESET_CMD, 20'h00000, 16'h0000);
      rd(`REG_STATUS, got);
      `CHECK(got, 32'h0000_0000)
      fetch(`OP_READ, 20'h00000, v);
      `CHECK(v, 16'h00A5)
      wr(`REG_PINS, 32'h0000_0002);
      #1 `CHECK(volt_nine, 1'b1)
      rd(`REG_PINS, got);
      `CHECK(got, 32'h0000_0002)
      for (int k = 0; k < 4; k++) begin
         fetch(`OP_HW_ID, 20'h08040 | 20'(k), v);
         `CHECK(v[7:0], id_exp(k, 1'b1))
      end
      fetch(`OP_HW_ID, 20'h00042, v);
      `CHECK(v[7:0], 8'h00)
      wr(`REG_PINS, 32'h0000_0001);
      #1 `CHECK(rst_n, 1'b0)
      wr(`REG_PINS, 32'h0000_0000);
      run_op(4'hF, 20'h00000, 16'h0000);
      rd(`REG_STATUS, got);
      `CHECK(got, 32'h0000_0004)
      $display("identification and hold done");
   endtask : t_ident
   // Hang guard: ceiling well above the several hundred cycles the run needs.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_program();
      t_ident();
      conclude();
   end
endmodule : flash_mode_protect_control_test
bind flash_host_ctl flash_host_ctl_asserts chk (.mclk(mclk), .reset(reset),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
   .flash_reset_n(flash_reset_n));
